// file: rtl/hub_serial_port_interrupt_config.sv
`timescale 1ns/1ps
// Event flags, masks, portable hub settings and interrupt pin of the hub
//
// Behaviour
// - Status bit 7 reads 1 while the pin is held low by an unmasked event.
// - Writing 0 to status bit 7 releases the pin; writing 1 changes nothing.
// - Status bit 4 sets on suspend entry and holds until written 0.
// - Status bit 3 sets when the host configures the hub, cleared by 0.
// - Status bit 2 sets on a port power update, cleared by writing 0.
// - Mask bit 4 lets suspend entry pull the pin low.
// - Mask bit 3 lets the host configured event pull the pin low.
// - Mask bit 2 lets a port power update pull the pin low.
// - Settings bit 7 keeps the internal clock running in suspend.
// - Settings bit 6 makes the pin a level suspend indication.
// - Settings bits 5:4 read only the window code, 00 meaning 95 ms.
// - Squelch bits 2:0 choose the port 3 squelch level.
module hub_serial_port_interrupt_config
(
    input wire logic clock,
    input wire logic reset,
    input wire logic write_strobe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] write_data,
    output logic [7:0] read_data,
    input wire logic hub_suspended,
    input wire logic host_configured_pulse,
    input wire logic port_power_update_pulse,
    output logic int_n,
    output logic keep_clock_in_suspend,
    output logic [2:0] port3_squelch_level
);
    logic flag_write;
    logic enable_write;
    logic settings_write;
    logic squelch_write;
    logic suspended_seen;
    logic suspend_entry_pulse;
    logic suspend_entry_flag;
    logic host_configured_flag;
    logic port_power_update_flag;
    logic [7:0] event_enable_register;
    logic suspend_level_indication;
    logic int_asserted;
    logic next_int_asserted;
    logic unmasked_event;

    // Address decode of write strobes
    assign flag_write = write_strobe && reg_addr == hub_int_pkg::event_flag_addr;
    assign enable_write =
        write_strobe && reg_addr == hub_int_pkg::event_enable_addr;
    assign settings_write =
        write_strobe && reg_addr == hub_int_pkg::portable_hub_addr;
    assign squelch_write =
        write_strobe && reg_addr == hub_int_pkg::port3_squelch_addr;

    // Suspend entry edge, suspend level comes from same-clock logic
    always_ff @(posedge clock)
    begin
        if (reset)
            suspended_seen <= 1'b0;
        else
            suspended_seen <= hub_suspended;
    end
    assign suspend_entry_pulse = hub_suspended && !suspended_seen;

    // Sticky status flags
    event_flag_cell suspend_cell
    (
        .clock(clock),
        .reset(reset),
        .event_pulse(suspend_entry_pulse),
        .clear_write(flag_write),
        .write_bit(write_data[hub_int_pkg::suspend_entry_bit]),
        .flag(suspend_entry_flag)
    );
    event_flag_cell configured_cell
    (
        .clock(clock),
        .reset(reset),
        .event_pulse(host_configured_pulse),
        .clear_write(flag_write),
        .write_bit(write_data[hub_int_pkg::host_configured_bit]),
        .flag(host_configured_flag)
    );
    event_flag_cell power_cell
    (
        .clock(clock),
        .reset(reset),
        .event_pulse(port_power_update_pulse),
        .clear_write(flag_write),
        .write_bit(write_data[hub_int_pkg::port_power_update_bit]),
        .flag(port_power_update_flag)
    );

    // Mask register, implemented bits only
    always_ff @(posedge clock)
    begin
        if (reset)
            event_enable_register <= hub_int_pkg::event_enable_reset;
        else if (enable_write)
            event_enable_register <= write_data & 8'h1c;
    end

    // Events that are enabled to pull the pin low
    always_comb
    begin
        unmasked_event =
            (suspend_entry_pulse &&
             event_enable_register[hub_int_pkg::suspend_entry_bit]) ||
            (host_configured_pulse &&
             event_enable_register[hub_int_pkg::host_configured_bit]) ||
            (port_power_update_pulse &&
             event_enable_register[hub_int_pkg::port_power_update_bit]);
    end

    // Interrupt latch: an event wins over a release in the same cycle
    always_comb
    begin
        next_int_asserted = int_asserted;
        if (unmasked_event)
            next_int_asserted = 1'b1;
        else if (flag_write && !write_data[hub_int_pkg::int_asserted_bit])
            next_int_asserted = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            int_asserted <= 1'b0;
        else
            int_asserted <= next_int_asserted;
    end

    // Portable hub settings, window code fixed read only
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            keep_clock_in_suspend <= hub_int_pkg::portable_hub_reset[7];
            suspend_level_indication <= hub_int_pkg::portable_hub_reset[6];
        end
        else if (settings_write)
        begin
            keep_clock_in_suspend <=
                write_data[hub_int_pkg::keep_clock_bit];
            suspend_level_indication <=
                write_data[hub_int_pkg::suspend_level_bit];
        end
    end

    // Port 3 squelch selection
    always_ff @(posedge clock)
    begin
        if (reset)
            port3_squelch_level <= hub_int_pkg::port3_squelch_reset[2:0];
        else if (squelch_write)
            port3_squelch_level <= write_data[2:0];
    end

    // Pin: suspend level in level mode, latched event otherwise
    always_ff @(posedge clock)
    begin
        if (reset)
            int_n <= 1'b1;
        else if (suspend_level_indication)
            int_n <= !hub_suspended;
        else
            int_n <= !next_int_asserted;
    end

    // Read mux, reserved bits read zero
    always_comb
    begin
        read_data = 8'h00;
        unique case (reg_addr)
            hub_int_pkg::event_flag_addr:
                read_data = {int_asserted, 2'b00, suspend_entry_flag,
                    host_configured_flag, port_power_update_flag, 2'b00};
            hub_int_pkg::event_enable_addr:
                read_data = event_enable_register;
            hub_int_pkg::portable_hub_addr:
                read_data = {keep_clock_in_suspend, suspend_level_indication,
                    hub_int_pkg::config_window_95ms, 4'h0};
            hub_int_pkg::port3_squelch_addr:
                read_data = {5'h00, port3_squelch_level};
            default:
                read_data = 8'h00;
        endcase
    end
endmodule

// file: inc/hub_int_pkg.sv
// Register map, field positions and constants of the hub interrupt block
package hub_int_pkg;
    // Register offsets on the serial configuration port
    localparam logic [7:0] event_flag_addr = 8'he8;
    localparam logic [7:0] event_enable_addr = 8'he9;
    localparam logic [7:0] portable_hub_addr = 8'hee;
    localparam logic [7:0] port3_squelch_addr = 8'hf4;

    // Field positions
    localparam int int_asserted_bit = 7;
    localparam int suspend_entry_bit = 4;
    localparam int host_configured_bit = 3;
    localparam int port_power_update_bit = 2;
    localparam int keep_clock_bit = 7;
    localparam int suspend_level_bit = 6;
    localparam int config_window_lsb = 4;
    localparam int squelch_lsb = 0;

    // Values after reset
    localparam logic [7:0] event_flag_reset = 8'h00;
    localparam logic [7:0] event_enable_reset = 8'h00;
    localparam logic [7:0] portable_hub_reset = 8'h00;
    localparam logic [7:0] port3_squelch_reset = 8'h00;

    // Configuration window: code 00 means 95 ms
    localparam logic [1:0] config_window_95ms = 2'h0;
    localparam int config_window_time_ms = 95;
    localparam int clock_rate_hz = 50000000;
    localparam longint config_window_cycles =
        longint'(config_window_time_ms) * clock_rate_hz / 1000;

    // Squelch codes of downstream port 3
    typedef enum logic [2:0] {
        squelch_nominal, squelch_90, squelch_80, squelch_70,
        squelch_60, squelch_50, squelch_120, squelch_110
    } squelch_level_t;
endpackage

// file: rtl/event_flag_cell.sv
`timescale 1ns/1ps
// One sticky event flag: set by hardware, cleared by writing zero
module event_flag_cell
(
    input wire logic clock,
    input wire logic reset,
    input wire logic event_pulse,
    input wire logic clear_write,
    input wire logic write_bit,
    output logic flag
);
    // Set wins over a clear in the same cycle; written one has no effect
    always_ff @(posedge clock)
    begin
        if (reset)
            flag <= 1'b0;
        else if (event_pulse)
            flag <= 1'b1;
        else if (clear_write && !write_bit)
            flag <= 1'b0;
    end
endmodule

// file: dv/hub_int_monitor.sv
// Port checker of the hub interrupt block
`timescale 1ns/1ps
module hub_int_monitor
(
    input logic clock, reset, write_strobe, hub_suspended, int_n,
    input logic host_configured_pulse, port_power_update_pulse,
    input logic keep_clock_in_suspend,
    input logic [7:0] reg_addr, write_data, read_data,
    input logic [2:0] port3_squelch_level
);
    logic [7:0] msk;
    logic lvl;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Shadow of the mask and of the level mode bit
    always_ff @(posedge clock)
    begin
        if (reset)
            {msk, lvl} <= 9'h000;
        else if (write_strobe && reg_addr == 8'he9)
            msk <= write_data;
        else if (write_strobe && reg_addr == 8'hee)
            lvl <= write_data[6];
    end
    a_pin_release: assert property (write_strobe && reg_addr == 8'he8
        && !write_data[7] && !lvl && !host_configured_pulse
        && !port_power_update_pulse && !$rose(hub_suspended) |=> int_n)
        else $error("pin held");
    a_susp_pin: assert property ($rose(hub_suspended) && msk[4]
        && !lvl |=> !int_n) else $error("suspend lost");
    a_cfg_pin: assert property (host_configured_pulse && msk[3]
        && !lvl |=> !int_n) else $error("configure lost");
    a_power_pin: assert property (port_power_update_pulse && msk[2]
        && !lvl |=> !int_n) else $error("power lost");
    a_level_pin: assert property (lvl
        |=> int_n == !$past(hub_suspended)) else $error("level pin");
    a_flag_pin: assert property (reg_addr == 8'he8 && !lvl
        && $stable(lvl) |-> read_data[7] == !int_n) else $error("bit 7");
    a_keep_clock: assert property (write_strobe && reg_addr == 8'hee
        |=> keep_clock_in_suspend == $past(write_data[7]))
        else $error("keep clock");
    a_squelch_out: assert property (write_strobe && reg_addr == 8'hf4
        |=> port3_squelch_level == $past(write_data[2:0]))
        else $error("squelch");
    c_cfg: cover property (host_configured_pulse && msk[3]);
    c_lvl: cover property (lvl && hub_suspended);
    c_pwr: cover property (port_power_update_pulse && write_strobe);
endmodule
bind hub_serial_port_interrupt_config hub_int_monitor mon_u (.clock, .reset,
    .write_strobe, .hub_suspended, .int_n, .host_configured_pulse,
    .port_power_update_pulse, .keep_clock_in_suspend, .reg_addr,
    .write_data, .read_data, .port3_squelch_level);

// file: dv/soc_host_model.sv
// Processor side model of the serial configuration port
`timescale 1ns/1ps
module soc_host_model
(
    input logic clock,
    input logic [7:0] read_data,
    output logic write_strobe = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] write_data = 8'h5a
);
    // One write, then an idle cycle; data lines scrambled when unused
    task automatic wr(input logic [7:0] a, d);
        {write_strobe, reg_addr, write_data} = {1'b1, a, d};
        @(posedge clock);
        #1;
        write_strobe = 1'b0;
        write_data = ~d;
        @(posedge clock);
        #1;
    endtask
    // Read data taken at the falling edge, well away from register updates
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        @(negedge clock);
        d = read_data;
        @(posedge clock);
        #1;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench of the hub interrupt block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0, reset = 1'b1, sus = 1'b0, cfg = 1'b0, pw = 1'b0;
    logic write_strobe, int_n, keep_clock_in_suspend;
    logic [7:0] reg_addr, write_data, read_data, d;
    logic [2:0] port3_squelch_level;
    int num_errors = 0, tests_run = 0, cyc = 0;
    // Mask, event number, flags expected
    logic [19:0] rows [5] = '{20'h10090, 20'h08188, 20'h04284,
        20'h00108, 20'h18204};
    logic [7:0] addrs [5] = '{8'he8, 8'he9, 8'hee, 8'hf4, 8'hea};
    hub_serial_port_interrupt_config dut_u (.clock, .reset, .write_strobe,
        .reg_addr, .write_data, .read_data, .hub_suspended(sus),
        .host_configured_pulse(cfg), .port_power_update_pulse(pw), .int_n,
        .keep_clock_in_suspend, .port3_squelch_level);
    soc_host_model host_u (.clock, .read_data, .write_strobe, .reg_addr,
        .write_data);
    always #10 clock = ~clock;
    task automatic chk(string s, logic [7:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", s, e, g);
            num_errors++;
        end
    endtask
    task automatic rchk(logic [7:0] a, e);
        host_u.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    // Event number 0 suspend, 1 configured, 2 port power
    task automatic fire(int n);
        {pw, cfg, sus} = 3'b001 << n;
        step();
        {pw, cfg} = 2'b00;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) step();
        reset = 1'b0;
        foreach (rows[i])
        begin
            host_u.wr(8'he8, 8'h00);
            host_u.wr(8'he9, rows[i][19:12]);
            fire(rows[i][11:8]);
            rchk(8'he8, rows[i][7:0]);
            chk("pin", 8'(!rows[i][7]), 8'(int_n));
            sus = 1'b0;
            $display("row %0d done", i);
        end
        // A written 1 keeps the pin; a clear racing an event loses
        host_u.wr(8'he9, 8'h04);
        fire(2);
        host_u.wr(8'he8, 8'h80);
        rchk(8'he8, 8'h80);
        chk("held", 8'h00, 8'(int_n));
        fork
            host_u.wr(8'he8, 8'h00);
            fire(2);
        join
        rchk(8'he8, 8'h84);
        host_u.wr(8'he8, 8'h00);
        chk("free", 8'h01, 8'(int_n));
        // Read only window, clock kept, level pin
        host_u.wr(8'hee, 8'hf0);
        rchk(8'hee, 8'hc0);
        chk("clk", 8'h01, 8'(keep_clock_in_suspend));
        fire(0);
        chk("lvl", 8'h00, 8'(int_n));
        sus = 1'b0;
        step();
        chk("lvl", 8'h01, 8'(int_n));
        host_u.wr(8'hee, 8'h00);
        chk("clk", 8'h00, 8'(keep_clock_in_suspend));
        for (int c = 0; c < 8; c++)
        begin
            host_u.wr(8'hf4, 8'hf8 | 8'(c));
            rchk(8'hf4, 8'(c));
            chk("sq", 8'(c), 8'(port3_squelch_level));
        end
        $display("pin and settings tests done");
        // Second reset clears every register and every other output, and sets int_n high
        host_u.wr(8'he9, 8'hff);
        rchk(8'he9, 8'h1c);
        host_u.wr(8'hee, 8'h80);
        fire(1);
        chk("pre pin", 8'h00, 8'(int_n));
        reset = 1'b1;
        step();
        reset = 1'b0;
        foreach (addrs[j])
            rchk(addrs[j], 8'h00);
        chk("rst pin", 8'h01, 8'(int_n));
        chk("rst clk", 8'h00, 8'(keep_clock_in_suspend));
        chk("rst sq", 8'h00, 8'(port3_squelch_level));
        step();
        chk("rst pin", 8'h01, 8'(int_n));
        $display("reset test done");
        tally_and_finish();
    end
endmodule
